// [rtl/mesm_top.sv]
// engine memory map: raw samples, status word, configuration word
// assumes synchronous inputs on core_clk and a host port with one-cycle
// strobes, read data in the cycle after the read strobe
//
// Functional notes
// - raw samples readable at words 0..10
// - slot handle 4 bits, 0 to 10
// - differential local pair uses lower handle, word
// - remote pair written directly to lower word
// - voltages single-ended, handles/words 8, 9, 10
// - pairs one to three local or remote
// - status word at 0x80, upper bits zero
// - status bit 3 fundamental square wave
// - dip flags set after count, clear above
// - status reflects the compute pass just completed
// - busy interrupt once per sample period
// - configuration word 0x20, default 0x0030da20
// - temp compensation owner select, bit controlled
// - host pulse rate words 0x45, 0x49
// - otherwise pulse rate from summed powers
// - dip count field, default 218
// - temp owner flag at configuration bit 22
`timescale 1ns/1ps
`default_nettype none

module mesm_top #(
  parameter int unsigned SLOW_TICK_CYC = mesm_pkg::SLOW_TICK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // host port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // local multiplexer samples
  input  wire logic        adc_valid,
  input  wire logic [3:0]  slot_input_select,
  input  wire logic [31:0] adc_data,
  // isolation interface samples, pairs one to three
  input  wire logic [2:0]  remote_valid,
  input  wire logic [31:0] remote_data_pair1,
  input  wire logic [31:0] remote_data_pair2,
  input  wire logic [31:0] remote_data_pair3,
  // engine sums
  input  wire logic [31:0] summed_real_power,
  input  wire logic [31:0] summed_reactive_power,
  // outputs
  output logic             engine_busy_pulse,
  output logic             irq,
  output logic             internal_temp_comp_en,
  output logic      [31:0] pulse_rate_real,
  output logic      [31:0] pulse_rate_reactive
);

  // ==========================================================
  // registers
  logic [31:0] raw_q [mesm_pkg::NUM_RAW];
  logic [31:0] config_q;
  logic [31:0] dip_thr_q;
  logic [31:0] host_real_q;
  logic [31:0] host_react_q;
  logic [31:0] sum_real_q;
  logic [31:0] sum_react_q;
  logic [3:0]  diff_en_q;
  logic [2:0]  rmt_en_q;
  logic [3:0]  div_q;
  logic [3:0]  status_q;
  logic [3:0]  irq_sts_q;
  logic [3:0]  irq_mask_q;
  logic [2:0]  dip_flag_q;
  logic [11:0] dip_cnt_q [mesm_pkg::NUM_PHASE];
  logic        sq_q;
  logic [31:0] tick_cnt_q;
  logic        tick_q;
  logic [4:0]  frame_cnt_q;
  logic        pass_q;

  logic        wr_cfg;
  logic [11:0] dip_limit;
  logic [1:0]  ref_sel;
  logic [4:0]  frame_len;
  logic [2:0]  dip_d;
  logic [2:0]  dip_onset;
  logic        sq_d;
  logic [31:0] rdata_d;

  assign wr_cfg    = clk_en & reg_wr;
  assign dip_limit = config_q[mesm_pkg::CFG_DIPCNT_LSB +: 12];
  assign ref_sel   = config_q[mesm_pkg::CFG_REFSEL_LSB +: 2];
  assign frame_len = {div_q, 1'b1};

  // ==========================================================
  // host writable words
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_q     <= mesm_pkg::CONFIG_RST;
      dip_thr_q    <= mesm_pkg::DIP_THR_RST;
      host_real_q  <= '0;
      host_react_q <= '0;
      diff_en_q    <= '0;
      rmt_en_q     <= '0;
      div_q        <= mesm_pkg::DIV_RST;
      irq_mask_q   <= '0;
    end else if (wr_cfg) begin
      unique case (reg_addr)
        mesm_pkg::CONFIG_IDX:     config_q <= reg_wdata;
        mesm_pkg::DIP_THR_IDX:    dip_thr_q <= reg_wdata;
        mesm_pkg::HOST_REAL_IDX:  host_real_q <= reg_wdata;
        mesm_pkg::HOST_REACT_IDX: host_react_q <= reg_wdata;
        mesm_pkg::INPUT_CFG_IDX: begin
          diff_en_q <= reg_wdata[mesm_pkg::ICFG_DIFF_LSB +: 4];
          rmt_en_q  <= reg_wdata[mesm_pkg::ICFG_RMT_LSB +: 3];
          div_q     <= reg_wdata[mesm_pkg::ICFG_DIV_LSB +: 4];
        end
        mesm_pkg::IRQ_MASK_IDX:   irq_mask_q <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // raw sample words
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < mesm_pkg::NUM_RAW; i++) raw_q[i] <= '0;
    end else if (clk_en) begin
      // local slot: handle is the word, odd handle of a
      // differential pair and any remote pair are unused
      if (adc_valid && slot_input_select <= mesm_pkg::RAW_LAST_IDX[3:0])
      begin
        if (slot_input_select >= mesm_pkg::VOLT_FIRST_HANDLE) begin
          raw_q[slot_input_select] <= adc_data;
        end else if (slot_input_select[0]
                     && diff_en_q[slot_input_select[2:1]]) begin
          // handle unused in differential mode
        end else if (slot_input_select[2:1] != 2'h0
                     && rmt_en_q[slot_input_select[2:1] - 2'h1]) begin
          // remote pair ignores the multiplexer
        end else begin
          raw_q[slot_input_select] <= adc_data;
        end
      end
      if (remote_valid[0] && rmt_en_q[0]) raw_q[2] <= remote_data_pair1;
      if (remote_valid[1] && rmt_en_q[1]) raw_q[4] <= remote_data_pair2;
      if (remote_valid[2] && rmt_en_q[2])
        raw_q[6] <= remote_data_pair3;
    end
  end

  // ==========================================================
  // sample rate: frame of 2*div+1 slow clock periods
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (clk_en) begin
      tick_q <= (tick_cnt_q == SLOW_TICK_CYC - 1);
      if (tick_cnt_q == SLOW_TICK_CYC - 1) tick_cnt_q <= '0;
      else tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_q <= '0;
      pass_q      <= 1'b0;
    end else if (clk_en) begin
      pass_q <= 1'b0;
      if (tick_q) begin
        if (frame_cnt_q >= frame_len - 5'h1) begin
          frame_cnt_q <= '0;
          pass_q      <= 1'b1;
        end else begin
          frame_cnt_q <= frame_cnt_q + 5'h1;
        end
      end
    end
  end

  // ==========================================================
  // dip detection and square wave, evaluated per pass
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? (~v + 32'h1) : v;
  endfunction

  always_comb begin
    dip_d = dip_flag_q;
    for (int p = 0; p < mesm_pkg::NUM_PHASE; p++) begin
      if (mag(raw_q[8 + p]) > dip_thr_q) dip_d[p] = 1'b0;
      else if (mag(raw_q[8 + p]) < dip_thr_q
               && dip_cnt_q[p] + 12'h1 >= dip_limit) dip_d[p] = 1'b1;
    end
    unique case (ref_sel)
      2'h1:    sq_d = ~raw_q[9][31];
      2'h2:    sq_d = ~raw_q[10][31];
      default: sq_d = ~raw_q[8][31];
    endcase
  end

  assign dip_onset = dip_d & ~dip_flag_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < mesm_pkg::NUM_PHASE; p++) dip_cnt_q[p] <= '0;
      dip_flag_q <= '0;
      sq_q       <= 1'b0;
    end else if (clk_en && pass_q) begin
      for (int p = 0; p < mesm_pkg::NUM_PHASE; p++) begin
        if (mag(raw_q[8 + p]) >= dip_thr_q) dip_cnt_q[p] <= '0;
        else if (dip_cnt_q[p] != 12'hfff)
          dip_cnt_q[p] <= dip_cnt_q[p] + 12'h1;
      end
      dip_flag_q <= dip_d;
      sq_q       <= sq_d;
    end
  end

  // whole status word loads together at the end of a pass
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (clk_en && pass_q) begin
      status_q <= {sq_d, dip_d};
    end
  end

  // ==========================================================
  // engine sums and pulse rate source
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_real_q  <= '0;
      sum_react_q <= '0;
    end else if (clk_en && pass_q) begin
      sum_real_q  <= summed_real_power;
      sum_react_q <= summed_reactive_power;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_rate_real     <= '0;
      pulse_rate_reactive <= '0;
    end else if (clk_en) begin
      if (config_q[mesm_pkg::CFG_PULSE_BIT]) begin
        pulse_rate_real     <= host_real_q;
        pulse_rate_reactive <= host_react_q;
      end else begin
        pulse_rate_real     <= sum_real_q;
        pulse_rate_reactive <= sum_react_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_temp_comp_en <= 1'b1;
    end else if (clk_en) begin
      internal_temp_comp_en <= ~config_q[mesm_pkg::CFG_TEMP_BIT];
    end
  end

  // ==========================================================
  // interrupts: sticky, write one to clear, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_q <= '0;
    end else if (clk_en) begin
      irq_sts_q <= (irq_sts_q
                    & ~((reg_wr && reg_addr == mesm_pkg::IRQ_STATUS_IDX)
                        ? reg_wdata[3:0] : 4'h0))
                   | {dip_onset & {3{pass_q}}, pass_q};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq               <= 1'b0;
      engine_busy_pulse <= 1'b0;
    end else if (clk_en) begin
      irq               <= |(irq_sts_q & irq_mask_q);
      engine_busy_pulse <= pass_q;
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    rdata_d = '0;
    if (reg_addr <= mesm_pkg::RAW_LAST_IDX) begin
      rdata_d = raw_q[reg_addr[3:0]];
    end else begin
      unique case (reg_addr)
        mesm_pkg::CONFIG_IDX:     rdata_d = config_q;
        mesm_pkg::DIP_THR_IDX:    rdata_d = dip_thr_q;
        mesm_pkg::HOST_REAL_IDX:  rdata_d = host_real_q;
        mesm_pkg::HOST_REACT_IDX: rdata_d = host_react_q;
        mesm_pkg::STATUS_IDX:     rdata_d = {28'h0, status_q};
        mesm_pkg::SUM_REAL_IDX:   rdata_d = sum_real_q;
        mesm_pkg::SUM_REACT_IDX:  rdata_d = sum_react_q;
        mesm_pkg::INPUT_CFG_IDX:
          rdata_d = {20'h0, div_q, 1'b0, rmt_en_q, diff_en_q};
        mesm_pkg::IRQ_STATUS_IDX: rdata_d = {28'h0, irq_sts_q};
        mesm_pkg::IRQ_MASK_IDX:   rdata_d = {28'h0, irq_mask_q};
        default:                  rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_d : 32'h0;
    end
  end

endmodule // mesm_top

`default_nettype wire

// [shared/mesm_pkg.sv]
// package for the metering engine sample and status map
// assumes a word-addressed engine memory, 32-bit words
package mesm_pkg;

  // ==========================================================
  // widths
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned HANDLE_W  = 4;
  localparam int unsigned DIPCNT_W  = 12;
  localparam int unsigned DIV_W     = 4;
  localparam int unsigned NUM_RAW   = 11;
  localparam int unsigned NUM_PHASE = 3;
  localparam int unsigned NUM_RMT   = 3;
  localparam int unsigned NUM_PAIR  = 4;
  localparam int unsigned IRQ_W     = 4;

  // ==========================================================
  // engine word addresses
  localparam logic [7:0] RAW_LAST_IDX    = 8'h0a;
  localparam logic [7:0] CONFIG_IDX      = 8'h20;
  localparam logic [7:0] DIP_THR_IDX     = 8'h24;
  localparam logic [7:0] HOST_REAL_IDX   = 8'h45;
  localparam logic [7:0] HOST_REACT_IDX  = 8'h49;
  localparam logic [7:0] STATUS_IDX      = 8'h80;
  localparam logic [7:0] SUM_REAL_IDX    = 8'h84;
  localparam logic [7:0] SUM_REACT_IDX   = 8'h88;
  localparam logic [7:0] INPUT_CFG_IDX   = 8'hc0;
  localparam logic [7:0] IRQ_STATUS_IDX  = 8'hc1;
  localparam logic [7:0] IRQ_MASK_IDX    = 8'hc2;

  // ==========================================================
  // reset values
  localparam logic [31:0] CONFIG_RST     = 32'h0030da20;
  localparam logic [31:0] DIP_THR_RST    = 32'h00000000;
  localparam logic [3:0]  DIV_RST        = 4'h7;

  // ==========================================================
  // configuration word fields
  localparam int unsigned CFG_TEMP_BIT    = 22;
  localparam int unsigned CFG_DIPCNT_LSB  = 8;
  localparam int unsigned CFG_REFSEL_LSB  = 6;
  localparam int unsigned CFG_PULSE_BIT   = 4;

  // input configuration word fields
  localparam int unsigned ICFG_DIFF_LSB   = 0;
  localparam int unsigned ICFG_RMT_LSB    = 4;
  localparam int unsigned ICFG_DIV_LSB    = 8;

  // status word fields
  localparam int unsigned STS_SQ_BIT      = 3;

  // interrupt status fields
  localparam int unsigned IRQ_BUSY_BIT    = 0;
  localparam int unsigned IRQ_DIP_LSB     = 1;

  // ==========================================================
  // handles and timing
  localparam logic [3:0] VOLT_FIRST_HANDLE = 4'h8;
  localparam real        CORE_CLK_HZ       = 250.0e6;
  localparam real        SLOW_CLK_HZ       = 32768.0;
  localparam int unsigned SLOW_TICK_CYC    =
    int'($floor(CORE_CLK_HZ / SLOW_CLK_HZ));

endpackage

// [testbench/mesm_top_checker.sv]
// port checker for the engine map top
// assumes a bind onto mesm_top; shadows follow clk_en
`timescale 1ns/1ps
`default_nettype none
module mesm_top_checker #(
  parameter int unsigned SLOW_TICK_CYC = 4
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        engine_busy_pulse,
  input wire logic        irq,
  input wire logic        internal_temp_comp_en,
  input wire logic [31:0] pulse_rate_real,
  input wire logic [31:0] pulse_rate_reactive
);
  localparam int unsigned GAP_MAX = 31 * SLOW_TICK_CYC + 4;
  logic [31:0] cfg_q;
  logic [31:0] hreal_q;
  logic [31:0] hreac_q;
  logic [31:0] gap_q;
  logic [1:0]  quiet_q;
  // ==========================================================
  // shadows of host writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q   <= mesm_pkg::CONFIG_RST;
      hreal_q <= 32'h0;
      hreac_q <= 32'h0;
      quiet_q <= 2'h0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == mesm_pkg::CONFIG_IDX) cfg_q <= reg_wdata;
      if (reg_addr == mesm_pkg::HOST_REAL_IDX) hreal_q <= reg_wdata;
      if (reg_addr == mesm_pkg::HOST_REACT_IDX) hreac_q <= reg_wdata;
      quiet_q <= 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  // cycles since the last busy pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) gap_q <= 32'h0;
    else if (engine_busy_pulse) gap_q <= 32'h0;
    else gap_q <= gap_q + 32'h1;
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_status_upper_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == mesm_pkg::STATUS_IDX
    |-> reg_rdata[31:4] == 28'h0) else $error("status upper bits set");
  a_busy_one_cycle: assert property (
    engine_busy_pulse |=> !engine_busy_pulse) else $error("busy too long");
  a_busy_period: assert property (
    gap_q <= GAP_MAX) else $error("busy pulse missing");
  a_temp_owner: assert property (
    quiet_q == 2'h3 |-> internal_temp_comp_en == !cfg_q[22])
    else $error("temp owner wrong");
  a_host_pulse_rate: assert property (
    quiet_q == 2'h3 && cfg_q[4]
    |-> pulse_rate_real == hreal_q && pulse_rate_reactive == hreac_q)
    else $error("host pulse rate not followed");
  a_reset_defaults: assert property (
    $rose(rst_n) |-> internal_temp_comp_en && !irq && !engine_busy_pulse)
    else $error("reset outputs wrong");
  a_config_readback: assert property (
    $past(reg_rd) && $past(reg_addr) == mesm_pkg::CONFIG_IDX
    |-> reg_rdata == $past(cfg_q)) else $error("config readback wrong");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
endmodule // mesm_top_checker
bind mesm_top mesm_top_checker #(.SLOW_TICK_CYC(SLOW_TICK_CYC)) u_chk (
  .core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .engine_busy_pulse, .irq, .internal_temp_comp_en,
  .pulse_rate_real, .pulse_rate_reactive);
`default_nettype wire

// [testbench/mesm_front_model.sv]
// front end model: local multiplexer and isolation link samples
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none
module mesm_front_model (
  input  wire logic        core_clk,
  output logic             adc_valid,
  output logic [3:0]       slot_input_select,
  output logic [31:0]      adc_data,
  output logic [2:0]       remote_valid,
  output wire logic [31:0] remote_data_pair1,
  output wire logic [31:0] remote_data_pair2,
  output wire logic [31:0] remote_data_pair3
);
  logic [31:0] rdat [3];
  assign remote_data_pair1 = rdat[0];
  assign remote_data_pair2 = rdat[1];
  assign remote_data_pair3 = rdat[2];
  initial begin
    adc_valid = 1'b0;
    slot_input_select = 4'h0;
    adc_data = 32'h0;
    remote_valid = 3'h0;
    for (int k = 0; k < 3; k++) rdat[k] = 32'h0;
  end
  // one slot sample, then lines scrambled
  task automatic send_local(input logic [3:0] h, input logic [31:0] d);
    @(posedge core_clk);
    adc_valid <= 1'b1;
    slot_input_select <= h;
    adc_data <= d;
    @(posedge core_clk);
    adc_valid <= 1'b0;
    slot_input_select <= ~h;
    adc_data <= ~d;
  endtask
  // isolation link writes the pair's lower word
  task automatic send_remote(input int k, input logic [31:0] d);
    @(posedge core_clk);
    remote_valid <= 3'(1 << k);
    rdat[k] <= d;
    @(posedge core_clk);
    remote_valid <= 3'h0;
    rdat[k] <= ~d;
  endtask
endmodule // mesm_front_model
`default_nettype wire

// [testbench/metering_engine_sample_status_map_test.sv]
// self-checking bench for the engine sample and status map
// assumes mesm_top, the front end model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module metering_engine_sample_status_map_test;
  localparam int unsigned SLOW = 4;
  localparam logic [31:0] THR = 32'h00001000;
  logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, s_real = 32'h0, s_react = 32'h0;
  logic [31:0] reg_rdata, pr_real, pr_react, adc_data, rp1, rp2, rp3;
  logic adc_valid, busy, irq, tc_en;
  logic [3:0] sel;
  logic [2:0] rvalid;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  mesm_front_model fe (.core_clk(core_clk), .adc_valid(adc_valid),
    .slot_input_select(sel), .adc_data(adc_data), .remote_valid(rvalid),
    .remote_data_pair1(rp1), .remote_data_pair2(rp2),
    .remote_data_pair3(rp3));
  mesm_top #(.SLOW_TICK_CYC(SLOW)) dut (.core_clk(core_clk),
    .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_valid(adc_valid), .slot_input_select(sel),
    .adc_data(adc_data), .remote_valid(rvalid), .remote_data_pair1(rp1),
    .remote_data_pair2(rp2), .remote_data_pair3(rp3),
    .summed_real_power(s_real), .summed_reactive_power(s_react),
    .engine_busy_pulse(busy), .irq(irq), .internal_temp_comp_en(tc_en),
    .pulse_rate_real(pr_real), .pulse_rate_reactive(pr_react));
  // ==========================================================
  // helpers
  function automatic logic [31:0] sts(input logic [3:0] b);
    return {28'h0, b};
  endfunction
  function automatic logic [31:0] icfg(input logic [3:0] df,
                                       input logic [2:0] rm,
                                       input logic [3:0] dv);
    return {20'h0, dv, 1'b0, rm, df};
  endfunction
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic wait_busy(input int n);
    repeat (n) begin
      @(negedge core_clk);
      while (busy !== 1'b1) @(negedge core_clk);
    end
  endtask
  task automatic period(input int exp);
    int n;
    n = 0;
    wait_busy(1);
    do begin
      @(negedge core_clk);
      n++;
    end while (busy !== 1'b1);
    chk(32'(n), 32'(exp));
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d [11];
    logic [31:0] v;
    logic [31:0] w;
    void'($urandom(32'h4e53f06f));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    s_real <= $urandom;
    s_react <= $urandom;
    rchk(8'h20, 32'h0030da20);
    chk(32'(tc_en), 32'h1);
    for (int h = 0; h <= 10; h++) begin
      d[h] = $urandom;
      fe.send_local(4'(h), d[h]);
    end
    for (int h = 0; h <= 10; h++) rchk(8'(h), d[h]);
    wr(8'hc0, icfg(4'h2, 3'h0, 4'h7));
    fe.send_local(4'h3, ~d[3]);
    fe.send_local(4'h2, ~d[2]);
    fe.send_remote(0, d[2]);
    rchk(8'h03, d[3]);
    rchk(8'h02, ~d[2]);
    wr(8'hc0, icfg(4'he, 3'h7, 4'h7));
    for (int k = 0; k < 3; k++) begin
      v = $urandom;
      fe.send_remote(k, v);
      fe.send_local(4'(2 + 2 * k), ~v);
      rchk(8'(2 + 2 * k), v);
    end
    wr(8'hc0, icfg(4'h0, 3'h0, 4'h7));
    period(15 * SLOW);
    wr(8'hc0, icfg(4'h0, 3'h0, 4'h6));
    period(13 * SLOW);
    wr(8'h24, THR);
    wr(8'h20, 32'h00000300);
    wait_busy(1);
    fe.send_local(4'h8, THR - 32'h1);
    fe.send_local(4'h9, 32'h1 - THR);
    fe.send_local(4'ha, 32'h1);
    wait_busy(2);
    rchk(8'h80, sts(4'h8));
    wait_busy(1);
    rchk(8'h80, sts(4'hf));
    rchk(8'hc1, 32'h0000000f);
    fe.send_local(4'h8, 32'h0 - THR - 32'h5);
    wait_busy(2);
    rchk(8'h80, sts(4'h6));
    wr(8'h20, 32'h00000380);
    wait_busy(2);
    wr(8'h80, 32'hffffffff);
    rchk(8'h80, sts(4'he));
    rchk(8'hf0, 32'h0);
    wr(8'h20, 32'h00000340);
    wait_busy(2);
    rchk(8'h80, sts(4'h6));
    wr(8'hc2, 32'h0);
    wr(8'hc1, 32'hf);
    wait_busy(1);
    chk(32'(irq), 32'h0);
    wr(8'hc2, 32'h1);
    repeat (2) @(negedge core_clk);
    chk(32'(irq), 32'h1);
    wait_busy(1);
    wr(8'hc1, 32'h1);
    repeat (2) @(negedge core_clk);
    chk(32'(irq), 32'h0);
    v = $urandom;
    w = $urandom;
    wr(8'h45, v);
    wr(8'h49, w);
    wr(8'h20, 32'h00000310);
    repeat (3) @(negedge core_clk);
    chk(pr_real, v);
    chk(pr_react, w);
    wr(8'h20, 32'h00400300);
    wait_busy(1);
    chk(pr_real, s_real);
    chk(pr_react, s_react);
    chk(32'(tc_en), 32'h0);
    rchk(8'h20, 32'h00400300);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(8'h20, 32'h0);
    clk_en <= 1'b1;
    rchk(8'h20, 32'h00400300);
    chk(32'(tc_en), 32'h0);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk(8'h20, 32'h0030da20);
    give_verdict();
  end
endmodule // metering_engine_sample_status_map_test
`default_nettype wire
